// File: hw/pin_edge_detect.sv
// Purpose: detect a configurable edge on one external interrupt pin
// Assumes: pin is synchronous to aclk
// Notes: one instance per pin
`default_nettype none
module pin_edge_detect
   import vic_pkg::*;
(
   input wire logic aclk,
   input wire logic aresetn,
   input wire logic pin,
   input wire logic [1:0] mode,
   output logic hit
);
   logic prev_q, prev_d;

   // previous pin level
   always_comb begin
      prev_d = pin;
   end
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         prev_q <= 1'b0;
      end else begin
         prev_q <= prev_d;
      end
   end

   // edge selection
   always_comb begin
      case (mode)
         EDGE_RISE: hit = pin & ~prev_q;
         EDGE_FALL: hit = ~pin & prev_q;
         EDGE_BOTH: hit = pin ^ prev_q;
         default: hit = 1'b0;
      endcase
   end
endmodule
`default_nettype wire

// File: hw/prio_pick.sv
// Purpose: fixed-priority pick among pending sources
// Assumes: bit 0 is the highest priority
// Notes: one-hot grant, zero when nothing is ready
`default_nettype none
module prio_pick
   import vic_pkg::*;
#(
   parameter int N = NUM_SRC
) (
   input wire logic [N-1:0] req,
   output logic [N-1:0] grant
);
   // refuse an empty source set at elaboration
   if (N < 1) begin : g_bad_n
      $error("prio_pick needs at least one source");
   end

   // lowest index wins
   always_comb begin
      grant = '0;
      for (int i = N - 1; i >= 0; i--) begin
         if (req[i]) begin
            grant = '0;
            grant[i] = 1'b1;
         end
      end
   end
endmodule
`default_nettype wire

// File: hw/vectored_interrupt_controller.sv
// Purpose: five-source vectored interrupt controller with register access
// Assumes: core pulses return inputs for one cycle and acks vector calls
// Notes: status/mask event bits drive irq, cleared by writing one
//
// Our own choice: the AXI4-Lite slave port.
`default_nettype none
module vectored_interrupt_controller
   import vic_pkg::*;
(
   input wire logic aclk,
   input wire logic aresetn,
   input wire logic [7:0] s_axi_awaddr,
   input wire logic s_axi_awvalid,
   output logic s_axi_awready,
   input wire logic [31:0] s_axi_wdata,
   input wire logic [3:0] s_axi_wstrb,
   input wire logic s_axi_wvalid,
   output logic s_axi_wready,
   output logic [1:0] s_axi_bresp,
   output logic s_axi_bvalid,
   input wire logic s_axi_bready,
   input wire logic [7:0] s_axi_araddr,
   input wire logic s_axi_arvalid,
   output logic s_axi_arready,
   output logic [31:0] s_axi_rdata,
   output logic [1:0] s_axi_rresp,
   output logic s_axi_rvalid,
   input wire logic s_axi_rready,
   input wire logic ext_irq_pin_0,
   input wire logic ext_irq_pin_1,
   input wire logic timer_overflow,
   input wire logic tick_timeout,
   input wire logic clock_timeout,
   input wire logic second_phase_clock,
   input wire logic stack_full,
   input wire logic return_from_interrupt,
   output logic call_valid,
   output logic [7:0] call_vector,
   input wire logic call_ack,
   output logic irq
);
   // control state
   logic master_irq_enable_q, master_irq_enable_d;
   src_vec_t en_q, en_d;
   src_vec_t flag_q, flag_d;
   vector_call_t call_q, call_d;
   logic [3:0] edge_cfg_q, edge_cfg_d;
   logic [NUM_EVT-1:0] evt_q, evt_d, evt_mask_q, evt_mask_d;
   logic t2_prev_q, t2_prev_d;
   // bus state
   logic aw_full_q, aw_full_d, w_full_q, w_full_d;
   logic [7:0] aw_addr_q, aw_addr_d;
   logic [31:0] w_data_q, w_data_d;
   logic [3:0] w_strb_q, w_strb_d;
   logic bvalid_q, bvalid_d, rvalid_q, rvalid_d;
   logic [1:0] bresp_q, bresp_d, rresp_q, rresp_d;
   logic [31:0] rdata_q, rdata_d;

   logic [NUM_SRC-1:0] hits, eligible, grant;
   logic t2_rise, do_write, do_read, wr_hit;
   logic [7:0] ctrl_low, ctrl_high, wbyte;

   // external pin edge detectors
   pin_edge_detect u_edge0 (
      .aclk(aclk),
      .aresetn(aresetn),
      .pin(ext_irq_pin_0),
      .mode(edge_cfg_q[1:0]),
      .hit(hits[0])
   );
   pin_edge_detect u_edge1 (
      .aclk(aclk),
      .aresetn(aresetn),
      .pin(ext_irq_pin_1),
      .mode(edge_cfg_q[3:2]),
      .hit(hits[1])
   );
   assign hits[2] = timer_overflow;
   assign hits[3] = tick_timeout;
   assign hits[4] = clock_timeout;

   // sources ready for service: flag, own enable, master enable, room on stack
   assign eligible = flag_q.src & en_q.src & {NUM_SRC{master_irq_enable_q & ~stack_full}};
   prio_pick #(.N(NUM_SRC)) u_pick (
      .req(eligible),
      .grant(grant)
   );
   assign t2_rise = second_phase_clock & ~t2_prev_q;

   // register images
   assign ctrl_low = {1'b0, flag_q.src[2:0], en_q.src[2:0], master_irq_enable_q};
   assign ctrl_high = {2'b00, flag_q.src[4:3], 2'b00, en_q.src[4:3]};

   // bus handshakes
   assign s_axi_awready = ~aw_full_q;
   assign s_axi_wready = ~w_full_q;
   assign s_axi_arready = ~rvalid_q;
   assign do_write = aw_full_q & w_full_q & ~bvalid_q;
   assign do_read = s_axi_arvalid & ~rvalid_q;
   assign wbyte = w_data_q[7:0];
   assign wr_hit = do_write & w_strb_q[0];

   // write channel capture and response
   always_comb begin
      aw_full_d = aw_full_q;
      w_full_d = w_full_q;
      aw_addr_d = aw_addr_q;
      w_data_d = w_data_q;
      w_strb_d = w_strb_q;
      bvalid_d = bvalid_q;
      bresp_d = bresp_q;
      if (s_axi_awvalid && !aw_full_q) begin
         aw_full_d = 1'b1;
         aw_addr_d = s_axi_awaddr;
      end
      if (s_axi_wvalid && !w_full_q) begin
         w_full_d = 1'b1;
         w_data_d = s_axi_wdata;
         w_strb_d = s_axi_wstrb;
      end
      if (do_write) begin
         aw_full_d = 1'b0;
         w_full_d = 1'b0;
         bvalid_d = 1'b1;
         case (aw_addr_q[7:2])
            IDX_CTRL_LOW[5:0], IDX_CTRL_HIGH[5:0], IDX_IRQ_STATUS[5:0],
            IDX_IRQ_MASK[5:0], IDX_EDGE_CFG[5:0]: bresp_d = RESP_OKAY;
            default: bresp_d = RESP_SLVERR;
         endcase
      end else if (bvalid_q && s_axi_bready) begin
         bvalid_d = 1'b0;
      end
   end

   // read channel
   always_comb begin
      rvalid_d = rvalid_q;
      rdata_d = rdata_q;
      rresp_d = rresp_q;
      if (do_read) begin
         rvalid_d = 1'b1;
         rresp_d = RESP_OKAY;
         case (s_axi_araddr[7:2])
            IDX_CTRL_LOW[5:0]: rdata_d = {24'h000000, ctrl_low};
            IDX_CTRL_HIGH[5:0]: rdata_d = {24'h000000, ctrl_high};
            IDX_IRQ_STATUS[5:0]: rdata_d = {{(32 - NUM_EVT){1'b0}}, evt_q};
            IDX_IRQ_MASK[5:0]: rdata_d = {{(32 - NUM_EVT){1'b0}}, evt_mask_q};
            IDX_EDGE_CFG[5:0]: rdata_d = {28'h0000000, edge_cfg_q};
            default: begin
               rdata_d = 32'h00000000;
               rresp_d = RESP_SLVERR;
            end
         endcase
      end else if (rvalid_q && s_axi_rready) begin
         rvalid_d = 1'b0;
      end
   end

   // flags, enables, vectoring and event status
   always_comb begin
      master_irq_enable_d = master_irq_enable_q;
      en_d = en_q;
      flag_d = flag_q;
      call_d = call_q;
      edge_cfg_d = edge_cfg_q;
      evt_d = evt_q;
      evt_mask_d = evt_mask_q;
      t2_prev_d = second_phase_clock;
      // software writes first, hardware effects after so they win
      if (wr_hit) begin
         case (aw_addr_q[7:2])
            IDX_CTRL_LOW[5:0]: begin
               master_irq_enable_d = wbyte[LOW_MASTER];
               en_d.src[2:0] = wbyte[LOW_TIMER_EN:LOW_EXT0_EN];
               flag_d.src[2:0] = wbyte[LOW_TIMER_FLAG:LOW_EXT0_FLAG];
            end
            IDX_CTRL_HIGH[5:0]: begin
               en_d.src[4:3] = wbyte[HIGH_CLOCK_EN:HIGH_TICK_EN];
               flag_d.src[4:3] = wbyte[HIGH_CLOCK_FLAG:HIGH_TICK_FLAG];
            end
            IDX_IRQ_STATUS[5:0]: evt_d = evt_q & ~wbyte[NUM_EVT-1:0];
            IDX_IRQ_MASK[5:0]: evt_mask_d = wbyte[NUM_EVT-1:0];
            IDX_EDGE_CFG[5:0]: edge_cfg_d = wbyte[3:0];
            default: ;
         endcase
      end
      // core return restores master enable; plain return has no input
      if (return_from_interrupt) begin
         master_irq_enable_d = 1'b1;
      end
      // the core pushes only the program counter when it takes the call
      if (call_q.valid && call_ack) begin
         call_d.valid = 1'b0;
      end
      // service on the second-phase rising edge, one source only
      if (t2_rise && !call_q.valid) begin
         if (|grant) begin
            call_d.valid = 1'b1;
            master_irq_enable_d = 1'b0;
            flag_d.src = flag_d.src & ~grant;
            evt_d[0] = 1'b1;
            unique case (1'b1)
               grant[0]: call_d.addr = VEC_EXT0;
               grant[1]: call_d.addr = VEC_EXT1;
               grant[2]: call_d.addr = VEC_TIMER;
               grant[3]: call_d.addr = VEC_TICK;
               default: call_d.addr = VEC_CLOCK;
            endcase
         end else if (stack_full && |(flag_q.src & en_q.src) && master_irq_enable_q) begin
            evt_d[1] = 1'b1;
         end
      end
      // new requests latch and win over any clear
      flag_d.src = flag_d.src | hits;
   end

   // registers
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         master_irq_enable_q <= 1'b0;
         en_q <= '0;
         flag_q <= '0;
         call_q <= '0;
         edge_cfg_q <= 4'h0;
         evt_q <= '0;
         evt_mask_q <= '0;
         t2_prev_q <= 1'b0;
         aw_full_q <= 1'b0;
         w_full_q <= 1'b0;
         aw_addr_q <= 8'h00;
         w_data_q <= 32'h00000000;
         w_strb_q <= 4'h0;
         bvalid_q <= 1'b0;
         bresp_q <= RESP_OKAY;
         rvalid_q <= 1'b0;
         rdata_q <= 32'h00000000;
         rresp_q <= RESP_OKAY;
      end else begin
         master_irq_enable_q <= master_irq_enable_d;
         en_q <= en_d;
         flag_q <= flag_d;
         call_q <= call_d;
         edge_cfg_q <= edge_cfg_d;
         evt_q <= evt_d;
         evt_mask_q <= evt_mask_d;
         t2_prev_q <= t2_prev_d;
         aw_full_q <= aw_full_d;
         w_full_q <= w_full_d;
         aw_addr_q <= aw_addr_d;
         w_data_q <= w_data_d;
         w_strb_q <= w_strb_d;
         bvalid_q <= bvalid_d;
         bresp_q <= bresp_d;
         rvalid_q <= rvalid_d;
         rdata_q <= rdata_d;
         rresp_q <= rresp_d;
      end
   end

   // outputs
   assign s_axi_bvalid = bvalid_q;
   assign s_axi_bresp = bresp_q;
   assign s_axi_rvalid = rvalid_q;
   assign s_axi_rdata = rdata_q;
   assign s_axi_rresp = rresp_q;
   assign call_valid = call_q.valid;
   assign call_vector = call_q.addr;
   assign irq = |(evt_q & evt_mask_q);

   // checks
   a_timer_vector: assert property (@(posedge aclk) disable iff (!aresetn)
      (t2_rise && !call_q.valid && eligible == 5'b00100) |=> call_valid && call_vector == VEC_TIMER)
      else $error("timer vector not issued");
   a_tick_vector: assert property (@(posedge aclk) disable iff (!aresetn)
      (t2_rise && !call_q.valid && eligible == 5'b01000) |=> call_vector == VEC_TICK && !master_irq_enable_q)
      else $error("tick vector wrong");
   a_clock_vector: assert property (@(posedge aclk) disable iff (!aresetn)
      (t2_rise && !call_q.valid && eligible == 5'b10000) |=> call_vector == VEC_CLOCK)
      else $error("clock vector wrong");
   a_return_from_interrupt_sets: assert property (@(posedge aclk) disable iff (!aresetn)
      return_from_interrupt |=> master_irq_enable_q)
      else $error("return did not set master enable");
   // lower pending requests survive the service of external 0
   a_prio_ext0: assert property (@(posedge aclk) disable iff (!aresetn)
      (t2_rise && !call_q.valid && eligible[0] && !wr_hit) |=> call_vector == VEC_EXT0 &&
      (flag_q.src[4:1] & $past(eligible[4:1])) == $past(eligible[4:1]))
      else $error("priority order broken");
   a_master_mask: assert property (@(posedge aclk) disable iff (!aresetn)
      (!master_irq_enable_q && !call_q.valid) |=> !call_valid)
      else $error("vector issued with master enable clear");
   a_stack_block: assert property (@(posedge aclk) disable iff (!aresetn)
      (stack_full && !call_q.valid) |=> !call_valid)
      else $error("vector issued on full stack");
   a_flag_sticky: assert property (@(posedge aclk) disable iff (!aresetn)
      (flag_q.src[2] && !t2_rise && !wr_hit) |=> flag_q.src[2])
      else $error("timer flag dropped");
   a_t2_only: assert property (@(posedge aclk) disable iff (!aresetn)
      (!t2_rise && !call_q.valid) |=> !call_valid)
      else $error("vector issued off phase edge");
   // unused control bits come back as zero on the bus
   a_ctrl_low_bit7: assert property (@(posedge aclk) disable iff (!aresetn)
      (do_read && (s_axi_araddr[7:2] == IDX_CTRL_LOW[5:0] || s_axi_araddr[7:2] == IDX_CTRL_HIGH[5:0]))
      |=> s_axi_rdata[31:7] == '0 && ($past(s_axi_araddr[7:2]) != IDX_CTRL_HIGH[5:0] ||
      (s_axi_rdata[6] == 1'b0 && s_axi_rdata[3:2] == 2'b00)))
      else $error("unused bits not zero");
endmodule
`default_nettype wire

// File: shared/vic_pkg.sv
// Purpose: constants and types for the vectored interrupt controller
// Assumes: AXI4-Lite slave with 32-bit data, registers in the low byte
// Notes: printed offsets are not all multiples of four, so they are indices
`default_nettype none
package vic_pkg;
   localparam logic [7:0] IDX_CTRL_LOW = 8'h0B;
   localparam logic [7:0] IDX_CTRL_HIGH = 8'h1E;
   localparam logic [7:0] IDX_IRQ_STATUS = 8'h20;
   localparam logic [7:0] IDX_IRQ_MASK = 8'h21;
   localparam logic [7:0] IDX_EDGE_CFG = 8'h22;
   localparam int LOW_MASTER = 0;
   localparam int LOW_EXT0_EN = 1;
   localparam int LOW_EXT1_EN = 2;
   localparam int LOW_TIMER_EN = 3;
   localparam int LOW_EXT0_FLAG = 4;
   localparam int LOW_EXT1_FLAG = 5;
   localparam int LOW_TIMER_FLAG = 6;
   localparam int HIGH_TICK_EN = 0;
   localparam int HIGH_CLOCK_EN = 1;
   localparam int HIGH_TICK_FLAG = 4;
   localparam int HIGH_CLOCK_FLAG = 5;
   localparam logic [7:0] CTRL_RESET = 8'h00;
   localparam logic [7:0] VEC_EXT0 = 8'h04;
   localparam logic [7:0] VEC_EXT1 = 8'h08;
   localparam logic [7:0] VEC_TIMER = 8'h0C;
   localparam logic [7:0] VEC_TICK = 8'h10;
   localparam logic [7:0] VEC_CLOCK = 8'h14;
   localparam int NUM_SRC = 5;
   localparam logic [1:0] RESP_OKAY = 2'b00;
   localparam logic [1:0] RESP_SLVERR = 2'b10;
   // status bit: 0 vector issued, 1 request refused for full stack
   localparam int NUM_EVT = 2;
   typedef enum logic [1:0] {
      EDGE_RISE,
      EDGE_FALL,
      EDGE_BOTH
   } edge_mode_t;
   typedef struct packed {
      logic [4:0] src; // clock, tick, timer, ext1, ext0
   } src_vec_t;
   typedef struct packed {
      logic valid;
      logic [7:0] addr;
   } vector_call_t;
endpackage
`default_nettype wire

// File: verification/core_model.sv
// Purpose: core side partner: takes vector calls, counts stack, returns
// Assumes: ret_req is a one cycle pulse from the bench
// Notes: slow holds the call acknowledge back two more cycles
`default_nettype none
module core_model #(
   parameter int DEPTH = 2
) (
   input wire logic aclk,
   input wire logic aresetn,
   input wire logic call_valid,
   input wire logic slow,
   input wire logic ret_req,
   output logic call_ack,
   output logic stack_full,
   output logic return_from_interrupt,
   output logic second_phase_clock
);
   timeunit 1ns;
   timeprecision 1ps;
   int depth;
   int wait_n;
   logic [1:0] ph;
   // stack is full at the nesting limit
   assign stack_full = (depth == DEPTH);
   assign second_phase_clock = (ph == 2'h3);
   // phase pulse every fourth cycle, acknowledge, stack count
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         depth <= 0;
         wait_n <= 0;
         ph <= 2'h0;
         call_ack <= 1'b0;
         return_from_interrupt <= 1'b0;
      end else begin
         ph <= ph + 2'h1;
         call_ack <= call_valid && !call_ack && (!slow || wait_n >= 2);
         wait_n <= (call_valid && !call_ack) ? wait_n + 1 : 0;
         if (call_valid && call_ack) depth <= depth + 1;
         else if (return_from_interrupt) depth <= depth - 1;
         // only interrupt returns pop; no plain calls are made
         return_from_interrupt <= ret_req && depth > 0;
      end
   end
endmodule
`default_nettype wire

// File: verification/tb.sv
// Purpose: self-checking bench for the vectored interrupt controller
// Assumes: registers reached over AXI4-Lite at index times four
// Notes: integer model of both control registers predicts each vector
`default_nettype none
module tb
   import vic_pkg::*;
;
   timeunit 1ns;
   timeprecision 1ps;
   logic aclk, aresetn, s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
   logic [7:0] s_axi_awaddr, s_axi_araddr, call_vector;
   logic [31:0] s_axi_wdata, s_axi_rdata;
   logic [3:0] s_axi_wstrb;
   logic [1:0] s_axi_bresp, s_axi_rresp;
   logic s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
   logic ext_irq_pin_0, ext_irq_pin_1, timer_overflow, tick_timeout, clock_timeout;
   logic second_phase_clock, stack_full, return_from_interrupt, call_valid, call_ack, irq;
   logic slow, ret_req;
   logic [7:0] calls[$];
   int checked, mismatches, seed, lo, hi;
   vectored_interrupt_controller i_vectored_interrupt_controller (.aclk, .aresetn,
      .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid,
      .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid,
      .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .ext_irq_pin_0,
      .ext_irq_pin_1, .timer_overflow, .tick_timeout, .clock_timeout, .second_phase_clock,
      .stack_full, .return_from_interrupt, .call_valid, .call_vector, .call_ack, .irq);
   core_model #(.DEPTH(2)) i_core_model (.aclk, .aresetn, .call_valid, .slow, .ret_req,
      .call_ack, .stack_full, .return_from_interrupt, .second_phase_clock);
   // record each accepted vector call
   always @(negedge aclk) if (call_valid === 1'b1 && call_ack === 1'b1) calls.push_back(call_vector);
   task automatic chk(input logic ok, input string m);
      checked++;
      if (ok !== 1'b1) begin
         mismatches++;
         $display("Error %0t: %s", $time, m);
      end
   endtask
   task automatic final_report();
      $display("checked %0d mismatches %0d", checked, mismatches);
      if (mismatches == 0 && checked > 0) $display("ALL CHECKS OK");
      else $display("CHECKS NOT OK");
      $finish;
   endtask
   task automatic hang();
      chk(1'b0, "wait ran out");
      final_report();
   endtask
   // one write; address and data released as each is taken
   task automatic wr(input logic [7:0] idx, input logic [7:0] d, input logic [1:0] er);
      logic a, w, b;
      logic [1:0] r;
      b = 1'b0;
      r = 2'b11;
      @(posedge aclk);
      s_axi_awaddr <= {idx[5:0], 2'b00};
      s_axi_wdata <= {24'h000000, d};
      s_axi_awvalid <= 1'b1;
      s_axi_wvalid <= 1'b1;
      s_axi_bready <= 1'b1;
      for (int n = 0; n < 50 && !b; n++) begin
         @(negedge aclk);
         a = s_axi_awvalid && s_axi_awready;
         w = s_axi_wvalid && s_axi_wready;
         b = s_axi_bvalid && s_axi_bready;
         r = s_axi_bresp;
         @(posedge aclk);
         if (a) s_axi_awvalid <= 1'b0;
         if (w) s_axi_wvalid <= 1'b0;
         if (b) s_axi_bready <= 1'b0;
      end
      if (!b) hang();
      chk(r === er, "write response");
   endtask
   // one read, compared with the expected byte and response
   task automatic rd(input logic [7:0] idx, input logic [7:0] e, input logic [1:0] er);
      logic a, b;
      logic [31:0] d;
      logic [1:0] r;
      b = 1'b0;
      d = 32'h0;
      r = 2'b11;
      @(posedge aclk);
      s_axi_araddr <= {idx[5:0], 2'b00};
      s_axi_arvalid <= 1'b1;
      s_axi_rready <= 1'b1;
      for (int n = 0; n < 50 && !b; n++) begin
         @(negedge aclk);
         a = s_axi_arvalid && s_axi_arready;
         b = s_axi_rvalid && s_axi_rready;
         d = s_axi_rdata;
         r = s_axi_rresp;
         @(posedge aclk);
         if (a) s_axi_arvalid <= 1'b0;
         if (b) s_axi_rready <= 1'b0;
      end
      if (!b) hang();
      chk(d === {24'h000000, e} && r === er, "read data");
   endtask
   task automatic quiet(input int n);
      int c;
      c = 0;
      repeat (n) begin
         @(negedge aclk);
         if (call_valid !== 1'b0) c++;
      end
      chk(c == 0, "unexpected call");
   endtask
   // expect the highest enabled pending source, then update the model
   task automatic serve();
      int f, e, i;
      logic [7:0] v;
      f = ((lo >> 4) & 7) | (((hi >> 4) & 3) << 3);
      e = ((lo >> 1) & 7) | ((hi & 3) << 3);
      i = 5;
      for (int k = 4; k >= 0; k--) if (((f & e) >> k) & 1) i = k;
      @(posedge aclk);
      slow <= 1'($random(seed));
      for (int n = 0; n < 300 && calls.size() == 0; n++) @(posedge aclk);
      if (calls.size() == 0) hang();
      v = calls.pop_front();
      chk(v === 8'(4 * (i + 1)), "vector");
      if (i < 3) lo &= ~(16 << i);
      else hi &= ~(16 << (i - 3));
      lo &= ~1;
      rd(IDX_CTRL_LOW, 8'(lo), RESP_OKAY);
      rd(IDX_CTRL_HIGH, 8'(hi), RESP_OKAY);
      quiet(12);
   endtask
   task automatic ret();
      @(posedge aclk);
      ret_req <= 1'b1;
      @(posedge aclk);
      ret_req <= 1'b0;
      lo |= 1;
      repeat (3 + ($random(seed) & 3)) @(posedge aclk);
   endtask
   task automatic tmr();
      @(posedge aclk);
      timer_overflow <= 1'b1;
      @(posedge aclk);
      timer_overflow <= 1'b0;
      lo |= 'h40;
   endtask
   initial begin
      aclk = 1'b0;
      forever #2 aclk = ~aclk;
   end
   // main sequence
   initial begin
      seed = 59;
      checked = 0;
      mismatches = 0;
      aresetn = 1'b0;
      {s_axi_awaddr, s_axi_araddr, s_axi_wdata} = '0;
      {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = '0;
      s_axi_wstrb = 4'hF;
      {ext_irq_pin_0, ext_irq_pin_1, timer_overflow, tick_timeout, clock_timeout} = '0;
      {slow, ret_req} = '0;
      repeat (12) @(posedge aclk);
      aresetn <= 1'b1;
      rd(IDX_CTRL_LOW, CTRL_RESET, RESP_OKAY);
      rd(IDX_CTRL_HIGH, CTRL_RESET, RESP_OKAY);
      rd(8'h30, 8'h00, RESP_SLVERR);
      wr(8'h30, 8'($random(seed)), RESP_SLVERR);
      wr(IDX_CTRL_LOW, 8'h8E, RESP_OKAY);
      lo = 'h0E;
      rd(IDX_CTRL_LOW, 8'(lo), RESP_OKAY);
      wr(IDX_CTRL_HIGH, 8'hCF, RESP_OKAY);
      hi = 'h03;
      rd(IDX_CTRL_HIGH, 8'(hi), RESP_OKAY);
      wr(IDX_EDGE_CFG, 8'h04, RESP_OKAY);
      wr(IDX_IRQ_MASK, 8'h01, RESP_OKAY);
      ext_irq_pin_1 <= 1'b1;
      rd(IDX_CTRL_LOW, 8'(lo), RESP_OKAY);
      ext_irq_pin_1 <= 1'b0;
      ext_irq_pin_0 <= 1'b1;
      {clock_timeout, tick_timeout, timer_overflow} <= 3'b111;
      @(posedge aclk);
      {clock_timeout, tick_timeout, timer_overflow} <= 3'b000;
      lo |= 'h70;
      hi |= 'h30;
      quiet(20);
      rd(IDX_CTRL_LOW, 8'(lo), RESP_OKAY);
      rd(IDX_CTRL_HIGH, 8'(hi), RESP_OKAY);
      // ext0 disabled, master on: the rest come out in rank order
      lo = (lo & ~2) | 1;
      wr(IDX_CTRL_LOW, 8'(lo), RESP_OKAY);
      repeat (4) begin
         serve();
         ret();
      end
      rd(IDX_CTRL_LOW, 8'(lo), RESP_OKAY);
      @(negedge aclk);
      chk(irq === 1'b1, "irq after vector");
      wr(IDX_IRQ_STATUS, 8'h01, RESP_OKAY);
      @(negedge aclk);
      chk(irq === 1'b0, "irq after clear");
      lo |= 2;
      wr(IDX_CTRL_LOW, 8'(lo), RESP_OKAY);
      serve();
      ret();
      // nest by software re-enable until the stack is full
      tmr();
      serve();
      lo |= 1;
      wr(IDX_CTRL_LOW, 8'(lo), RESP_OKAY);
      tmr();
      serve();
      lo |= 1;
      wr(IDX_CTRL_LOW, 8'(lo), RESP_OKAY);
      tmr();
      quiet(20);
      rd(IDX_CTRL_LOW, 8'(lo), RESP_OKAY);
      rd(IDX_IRQ_STATUS, 8'h03, RESP_OKAY);
      wr(IDX_IRQ_MASK, 8'h00, RESP_OKAY);
      @(negedge aclk);
      chk(irq === 1'b0, "irq masked");
      ret();
      serve();
      ret();
      ret();
      // pin 0 on both edges, pin 1 off; tick left pending behind external 0
      wr(IDX_EDGE_CFG, 8'h0E, RESP_OKAY);
      rd(IDX_EDGE_CFG, 8'h0E, RESP_OKAY);
      {ext_irq_pin_1, ext_irq_pin_0, tick_timeout} <= 3'b101;
      @(posedge aclk);
      tick_timeout <= 1'b0;
      lo |= 'h10;
      hi |= 'h10;
      serve();
      ret();
      serve();
      ret();
      rd(IDX_CTRL_LOW, 8'(lo), RESP_OKAY);
      final_report();
   end
endmodule
`default_nettype wire
